// file: irb_bridge.sv
/*
  Infrared remote code to serial bridge: pulse-width decoder, code
  translator, one-byte buffer, 8N1 sender with request/clear handshake,
  code indicator and a timed pulse on the nine-nine-nine-nine-nine sequence.
  Assumes the infrared receiver output and clear-to-send are synchronous
  to ref_clk; the pin driver merges irOut and irOe with the receiver.
*/
`include "irb_params.svh"

module irb_bridge #(
  parameter int BaudCycles    = (`IRB_CLK_HZ + `IRB_BAUD / 2) / `IRB_BAUD,
  parameter int TickCycles    = `IRB_TICK_US * (`IRB_CLK_HZ / 1000000),
  parameter int TimeoutTicks  = `IRB_TIMEOUT_MS * 1000 / `IRB_TICK_US,
  parameter int PulseTicks    = `IRB_PULSE_MS * 1000 / `IRB_TICK_US,
  parameter int FifoDepth     = 4
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic irIn,
  output logic      irOut,
  output logic      irOe,
  output logic      txOut,
  output logic      rtsN,
  input  wire logic ctsN,
  output logic      codeReceivedIndicator,
  output logic      auxResetPulse
);
  import irb_pkg::*;

  irb_tx_state_t  txState_q;
  irb_dec_state_t decState_q;
  logic [4:0]     porCnt_q;
  logic           run;
  logic [15:0]    divCnt_q;
  logic           tick;
  logic [4:0]     lenCnt_q;
  logic [3:0]     bitCnt_q;
  logic [11:0]    frame_q;
  logic           codeValid_q;
  logic [6:0]     code_q;
  logic           fifoInReady;
  logic           fifoOutValid;
  logic [7:0]     fifoOutData;
  logic           accept;
  logic           pop;
  logic [15:0]    baudCnt_q;
  logic           baudEnd;
  logic [2:0]     bitIdx_q;
  logic [7:0]     shift_q;
  logic [15:0]    waitCnt_q;
  logic [2:0]     nineCnt_q;
  logic [15:0]    pulseCnt_q;
  logic           nineHit;

  // -------------------------------------------------------------------------
  // Internal power-on reset
  // -------------------------------------------------------------------------
  // Holds everything quiet for a few cycles even if resetn is tied high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      porCnt_q <= '0;
    end else if (porCnt_q != 5'(`IRB_POR_CYCLES)) begin
      porCnt_q <= porCnt_q + 1'b1;
    end
  end
  assign run = (porCnt_q == 5'(`IRB_POR_CYCLES));

  // -------------------------------------------------------------------------
  // Measurement tick and pin refresh
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= '0;
    end else if (!run || divCnt_q == 16'(TickCycles - 1)) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1;
    end
  end
  assign tick = run && (divCnt_q == 16'(TickCycles - 1));

  // One-cycle high drive just before each sample resets the input trigger
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irOe <= 1'b0;
    end else begin
      irOe <= run && (divCnt_q == 16'(TickCycles - 3));
    end
  end
  assign irOut = 1'b1;

  // -------------------------------------------------------------------------
  // Pulse-width decoder
  // -------------------------------------------------------------------------
  // Low input is carrier; header, then 12 bits of low width 0.6 or 1.2 ms
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      decState_q  <= DEC_HUNT;
      lenCnt_q    <= '0;
      bitCnt_q    <= '0;
      frame_q     <= '0;
      codeValid_q <= 1'b0;
    end else begin
      codeValid_q <= 1'b0;
      if (tick) begin
        case (decState_q)
          DEC_HUNT: begin
            lenCnt_q <= 5'd1;
            if (!irIn) begin
              decState_q <= DEC_HEAD;
            end
          end
          DEC_HEAD: begin
            if (!irIn) begin
              lenCnt_q <= lenCnt_q + 1'b1;
              if (lenCnt_q >= 5'(`IRB_HDR_MAX)) begin
                decState_q <= DEC_HUNT;
              end
            end else if (lenCnt_q >= 5'(`IRB_HDR_MIN)) begin
              decState_q <= DEC_GAP;
              lenCnt_q   <= 5'd1;
              bitCnt_q   <= '0;
            end else begin
              decState_q <= DEC_HUNT;
            end
          end
          DEC_GAP: begin
            if (irIn) begin
              lenCnt_q <= lenCnt_q + 1'b1;
              if (lenCnt_q >= 5'(`IRB_GAP_MAX)) begin
                decState_q <= DEC_HUNT;
              end
            end else begin
              decState_q <= DEC_BIT;
              lenCnt_q   <= 5'd1;
            end
          end
          DEC_BIT: begin
            if (!irIn) begin
              lenCnt_q <= lenCnt_q + 1'b1;
              if (lenCnt_q >= 5'(`IRB_ONE_MAX)) begin
                decState_q <= DEC_HUNT;
              end
            end else if (lenCnt_q < 5'(`IRB_ZERO_MIN)) begin
              decState_q <= DEC_HUNT;
            end else begin
              // Widths between the two bands count as a one
              frame_q  <= {(lenCnt_q >= 5'(`IRB_ONE_MIN - 2)), frame_q[11:1]};
              bitCnt_q <= bitCnt_q + 1'b1;
              lenCnt_q <= 5'd1;
              if (bitCnt_q == 4'(`IRB_FRAME_BITS - 1)) begin
                codeValid_q <= 1'b1;            // Only complete frames count
                decState_q  <= DEC_HUNT;
              end else begin
                decState_q <= DEC_GAP;
              end
            end
          end
          default: decState_q <= DEC_HUNT;
        endcase
      end
    end
  end
  // Command sits in the first seven bits sent, least significant first
  assign code_q = frame_q[6:0];

  // -------------------------------------------------------------------------
  // Translation
  // -------------------------------------------------------------------------
  function automatic logic [6:0] xlate(input logic [6:0] c);
    logic [6:0] r;
    r = c;                                                   // Others pass
    if (c <= `IRB_KEY_LAST) begin
      r = c + `IRB_ASC_ONE;
    end else if (c == `IRB_KEY_ZERO) begin
      r = `IRB_ASC_ZERO;
    end else if (c == `IRB_KEY_ENTER) begin
      r = `IRB_ASC_CR;
    end else if (c == `IRB_KEY_POWER) begin
      r = `IRB_ASC_DOT;
    end else if (c == `IRB_KEY_JUMP) begin
      r = `IRB_ASC_BS;
    end else if (c >= `IRB_ASC_ONE && c <= `IRB_ASC_EIGHT) begin
      r = c - `IRB_ASC_ONE;
    end else if (c == `IRB_ASC_NINE) begin
      r = `IRB_KEY_JUMP;
    end else if (c == `IRB_ASC_ZERO) begin
      r = `IRB_KEY_ZERO;
    end else if (c == `IRB_ASC_CR) begin
      r = `IRB_KEY_ENTER;
    end else if (c == `IRB_ASC_DOT) begin
      r = `IRB_KEY_POWER;
    end
    return r;
  endfunction

  // -------------------------------------------------------------------------
  // Pending byte buffer
  // -------------------------------------------------------------------------
  // New codes are dropped while a byte is pending, so one byte at most
  assign accept = codeValid_q && fifoInReady && !fifoOutValid && (txState_q == TX_IDLE);
  assign pop    = (txState_q == TX_IDLE) && fifoOutValid;

  irb_fifo #(
    .Width (`IRB_DATA_BITS),
    .Depth (FifoDepth)
  ) uFifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inValid  (accept),
    .inReady  (fifoInReady),
    .inData   ({1'b0, xlate(code_q)}),
    .outValid (fifoOutValid),
    .outReady (pop),
    .outData  (fifoOutData)
  );

  // -------------------------------------------------------------------------
  // Serial sender
  // -------------------------------------------------------------------------
  assign baudEnd = (baudCnt_q == 16'(BaudCycles - 1));

  // Bit timer restarts on each state change
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      baudCnt_q <= '0;
    end else if (txState_q == TX_IDLE || txState_q == TX_WAIT || baudEnd) begin
      baudCnt_q <= '0;
    end else begin
      baudCnt_q <= baudCnt_q + 1'b1;
    end
  end

  // Sequence: wait for clear, start, 8 data, stop
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txState_q <= TX_IDLE;
      shift_q   <= '0;
      bitIdx_q  <= '0;
      waitCnt_q <= '0;
    end else begin
      case (txState_q)
        TX_IDLE: begin
          waitCnt_q <= '0;
          if (pop) begin
            shift_q   <= fifoOutData;
            txState_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          // Clear-to-send is looked at only here
          if (!ctsN) begin
            txState_q <= TX_START;
          end else if (waitCnt_q == 16'(TimeoutTicks)) begin
            txState_q <= TX_IDLE;                            // Byte discarded
          end else if (tick) begin
            waitCnt_q <= waitCnt_q + 1'b1;
          end
        end
        TX_START: begin
          bitIdx_q <= '0;
          if (baudEnd) begin
            txState_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (baudEnd) begin
            shift_q  <= {1'b0, shift_q[7:1]};                // LSB first
            bitIdx_q <= bitIdx_q + 1'b1;
            if (bitIdx_q == 3'(`IRB_DATA_BITS - 1)) begin
              txState_q <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (baudEnd) begin
            txState_q <= TX_IDLE;
          end
        end
        default: txState_q <= TX_IDLE;
      endcase
    end
  end

  // Registered line, request and indicator outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      txOut                 <= 1'b1;
      rtsN                  <= 1'b1;
      codeReceivedIndicator <= 1'b0;
    end else begin
      txOut <= (txState_q == TX_START) ? 1'b0 :
               (txState_q == TX_DATA)  ? shift_q[0] : 1'b1;  // Idle mark
      // Low through the stop bit, released only once back in idle
      rtsN  <= (txState_q == TX_IDLE) && !pop;
      codeReceivedIndicator <= accept || fifoOutValid ||
                               (txState_q != TX_IDLE);
    end
  end

  // -------------------------------------------------------------------------
  // Nine-sequence pulse
  // -------------------------------------------------------------------------
  assign nineHit = codeValid_q && (code_q == `IRB_NINE_KEY) &&
                   (nineCnt_q == 3'(`IRB_NINE_RUN - 1));

  // Any other valid key breaks the run
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nineCnt_q <= '0;
    end else if (codeValid_q) begin
      nineCnt_q <= (code_q != `IRB_NINE_KEY || nineHit) ? '0 : nineCnt_q + 1'b1;
    end
  end

  // Width counted in ticks; a repeat while active restarts the pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulseCnt_q    <= '0;
      auxResetPulse <= 1'b0;
    end else if (nineHit) begin
      pulseCnt_q    <= '0;
      auxResetPulse <= 1'b1;
    end else if (auxResetPulse && tick) begin
      pulseCnt_q <= pulseCnt_q + 1'b1;
      if (pulseCnt_q == 16'(PulseTicks - 1)) begin
        auxResetPulse <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  property p_idle_mark;
    @(posedge ref_clk) disable iff (!resetn)
    $past(txState_q) inside {TX_IDLE, TX_WAIT, TX_STOP} |-> txOut;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not high outside frame");

  property p_rts_wait;
    @(posedge ref_clk) disable iff (!resetn)
    txState_q != TX_IDLE |=> !rtsN;
  endproperty
  a_rts_wait: assert property (p_rts_wait) else $error("request high during send");

  property p_no_start_held;
    @(posedge ref_clk) disable iff (!resetn)
    txState_q == TX_WAIT && ctsN |=> txState_q != TX_START;
  endproperty
  a_no_start_held: assert property (p_no_start_held) else $error("started while held off");

  property p_timeout;
    @(posedge ref_clk) disable iff (!resetn)
    txState_q == TX_WAIT && ctsN && waitCnt_q == 16'(TimeoutTicks) |=> txState_q == TX_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("byte not discarded on timeout");

  property p_frame_done;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(txState_q == TX_START) |-> (txState_q != TX_WAIT && txState_q != TX_IDLE) [*8];
  endproperty
  a_frame_done: assert property (p_frame_done) else $error("frame abandoned");

  property p_msb_zero;
    @(posedge ref_clk) disable iff (!resetn)
    txState_q == TX_DATA && bitIdx_q == 3'd7 |=> !txOut;
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("top data bit not zero");

  property p_indicator;
    @(posedge ref_clk) disable iff (!resetn)
    accept |=> codeReceivedIndicator throughout (txState_q != TX_STOP) [*3];
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator dropped early");

  property p_pulse;
    @(posedge ref_clk) disable iff (!resetn)
    nineHit |=> auxResetPulse && pulseCnt_q == '0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("nine run gave no pulse");

  property p_por_quiet;
    @(posedge ref_clk) disable iff (!resetn)
    !run |-> rtsN && !codeReceivedIndicator && txOut && !irOe;
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("outputs active in power-on reset");

  property p_one_pending;
    @(posedge ref_clk) disable iff (!resetn)
    txState_q != TX_IDLE |-> !fifoOutValid;
  endproperty
  a_one_pending: assert property (p_one_pending) else $error("second byte accepted");

endmodule

// file: irb_bridge_tb_top.sv
/*
  Self-checking bench for the infrared to serial bridge.
  Assumes shortened timing parameters and the host model beside it.
*/
module irb_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK  = 10;
  localparam int BAUD  = 16;
  localparam int PULSE = 10;

  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       irIn = 1'b1;
  logic       holdOff = 1'b0;
  logic       dropEarly = 1'b0;
  logic       irOut, irOe, txOut, rtsN, ctsN;
  logic       codeReceivedIndicator, auxResetPulse, frameBad;
  logic [7:0] rxByte;
  int         rxCount;
  int         failCount = 0;
  int         checked = 0;
  int         oeSeen = 0;
  int         auxLen = 0;

  always #5 ref_clk = ~ref_clk;

  irb_bridge #(.BaudCycles(BAUD), .TickCycles(TICK), .TimeoutTicks(300),
    .PulseTicks(PULSE), .FifoDepth(4)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
    .irIn(irIn), .irOut(irOut), .irOe(irOe), .txOut(txOut), .rtsN(rtsN), .ctsN(ctsN),
    .codeReceivedIndicator(codeReceivedIndicator), .auxResetPulse(auxResetPulse));

  irb_host_model #(.BaudCycles(BAUD)) u_host (.ref_clk(ref_clk), .txOut(txOut),
    .rtsN(rtsN), .holdOff(holdOff), .dropEarly(dropEarly), .ctsN(ctsN),
    .rxByte(rxByte), .rxCount(rxCount), .frameBad(frameBad));

  // Pin refresh pulses and aux pulse width
  always @(posedge ref_clk) begin
    if (irOe === 1'b1 && irOut === 1'b1) oeSeen++;
    if (auxResetPulse === 1'b1) auxLen++;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      failCount++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  // Called at a falling edge; whole ticks keep the sample count exact
  task automatic irLevel(input logic lvl, input int ticks);
    irIn = lvl;
    repeat (ticks * TICK) @(negedge ref_clk);
  endtask

  task automatic irFrame(input logic [6:0] code);
    irLevel(1'b0, 21);
    for (int i = 0; i < 12; i++) begin
      irLevel(1'b1, 2);
      irLevel(1'b0, (i < 7 && code[i]) ? 8 : 4);
    end
    irIn = 1'b1;
  endtask

  task automatic waitRts(input logic lvl);
    int n;
    n = 0;
    while (rtsN !== lvl && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    check(rtsN, lvl);
  endtask

  task automatic sendCheck(input logic [6:0] code, input logic [7:0] want);
    int c0;
    int n;
    c0 = rxCount;
    n = 0;
    irFrame(code);
    waitRts(1'b0);
    check(codeReceivedIndicator, 1'b1);
    check(txOut, 1'b1);
    while (rxCount == c0 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    check(rxByte, want);
    check(frameBad, 1'b0);
    repeat (BAUD) @(negedge ref_clk);
    check(rtsN, 1'b1);
    check(codeReceivedIndicator, 1'b0);
    check(txOut, 1'b1);
    irLevel(1'b1, 10);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic resetTest;
    check({txOut, rtsN, codeReceivedIndicator, auxResetPulse}, 4'hC);
    irLevel(1'b1, 2);
    irLevel(1'b0, 10);
    irLevel(1'b1, 20);
    check(rtsN, 1'b1);
  endtask

  task automatic tableTest;
    logic [6:0] codes [13] = '{9, 11, 21, 59, 49, 52, 56, 48, 13, 46, 57, 100, 127};
    logic [7:0] wants [13] = '{48, 13, 46, 8, 0, 3, 7, 9, 11, 21, 59, 100, 127};
    for (int i = 0; i < 9; i++) sendCheck(7'(i), 8'(49 + i));
    for (int i = 0; i < 13; i++) begin
      dropEarly = (i > 10); // clear-to-send withdrawn mid-frame
      sendCheck(codes[i], wants[i]);
    end
    dropEarly = 1'b0;
  endtask

  // Pending byte starved of clear-to-send; a code arriving meanwhile is lost
  task automatic holdTest;
    int c0;
    c0 = rxCount;
    holdOff = 1'b1;
    irFrame(7'h05);
    waitRts(1'b0);
    irLevel(1'b1, 10);
    irFrame(7'h06);
    waitRts(1'b1);
    check(rxCount, c0);
    check(codeReceivedIndicator, 1'b0);
    holdOff = 1'b0;
    irLevel(1'b1, 10);
    sendCheck(7'h07, 8'h38);
  endtask

  task automatic auxTest;
    for (int i = 0; i < 4; i++) sendCheck(7'h08, 8'h39);
    check(auxLen, 0);
    sendCheck(7'h08, 8'h39);
    irLevel(1'b1, PULSE + 2);
    check(auxLen >= (PULSE - 1) * TICK && auxLen <= PULSE * TICK + 1, 1);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // --------------------
  // Sequence and watchdog
  // --------------------
  initial begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    resetTest;
    tableTest;
    holdTest;
    auxTest;
    check(oeSeen != 0, 1);
    wrap_up;
  end

  // Run needs roughly 40k cycles; 80k means a hang
  initial begin
    #800000;
    failCount++;
    wrap_up;
  end
endmodule

// file: irb_fifo.sv
/*
  Small first-in first-out buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
module irb_fifo #(
  parameter int Width = 8,
  parameter int Depth = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [Width-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [Width-1:0] outData
);

  localparam int AW = (Depth > 1) ? $clog2(Depth) : 1;

  logic [Width-1:0] mem [Depth];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // -------------------------------------------------------------------------
  // Handshake
  // -------------------------------------------------------------------------
  assign inReady  = (count_q != (AW+1)'(Depth));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  // Storage, no reset needed since reads are gated by count
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(Depth-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(Depth-1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule

// file: irb_host_model.sv
/*
  Host side model: grants clear-to-send and receives 8N1 bytes.
  Assumes txOut and rtsN come from the bridge, all on ref_clk.
*/
module irb_host_model #(
  parameter int BaudCycles = 16
) (
  input  wire logic       ref_clk,
  input  wire logic       txOut,
  input  wire logic       rtsN,
  input  wire logic       holdOff,
  input  wire logic       dropEarly,
  output logic            ctsN = 1'b1,
  output logic [7:0]      rxByte = 8'h00,
  output int              rxCount = 0,
  output logic            frameBad = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] reqDly = 3'h0;
  logic       busy   = 1'b0;

  // --------------------
  // Handshake
  // --------------------
  // Slow grant, a few cycles after the request
  always @(negedge ref_clk) begin
    reqDly <= {reqDly[1:0], ~rtsN};
    ctsN <= !(reqDly[2] && !rtsN && !holdOff && !(dropEarly && busy));
  end

  // --------------------
  // Receiver
  // --------------------
  // Mid-bit sampling, so a wrong bit time corrupts data
  always begin
    @(negedge txOut);
    busy = 1'b1;
    repeat (BaudCycles / 2) @(posedge ref_clk);
    frameBad = frameBad | txOut;
    for (int i = 0; i < 8; i++) begin
      repeat (BaudCycles) @(posedge ref_clk);
      rxByte[i] = txOut;
    end
    repeat (BaudCycles) @(posedge ref_clk);
    frameBad = frameBad | !txOut;
    rxCount++;
    busy = 1'b0;
  end
endmodule

// file: irb_params.svh
/*
  Constants for the infrared code to serial bridge: timing figures, decoder
  thresholds and code translation values.
  Assumes a 100 MHz reference clock and the includer's own module scope.
*/
// What this block does
// - Send 9600 baud, 8N1, LSB first
// - Serial output idles high
// - Request low from ready to stop or abort
// - Never start while clear-to-send high
// - Discard byte after 2 s hold-off
// - Clear-to-send checked only before start bit
// - Infrared low means carrier present
// - Indicator high from code until sent or discarded
// - Keys 99999 give 100 ms high pulse
// - Common control codes become ASCII values
// - Retransmit only validly decoded codes
// - Own power-on reset, no external needed
// - Forward code to ASCII translation table
// - Reverse ASCII to code translation table
// - Top data bit always sent zero
// - Pulse infrared pin high before measuring
`ifndef IRB_PARAMS_SVH
`define IRB_PARAMS_SVH

// ---------------------------------------------------------------------------
// Clock and serial timing
// ---------------------------------------------------------------------------
`define IRB_CLK_HZ        100000000
`define IRB_BAUD          9600
`define IRB_TICK_US       100
`define IRB_TIMEOUT_MS    2000
`define IRB_PULSE_MS      100
`define IRB_POR_CYCLES    16
`define IRB_DATA_BITS     8

// ---------------------------------------------------------------------------
// Decoder thresholds in 100 us ticks of low or high level, frame bits and nine-key run
// ---------------------------------------------------------------------------
`define IRB_HDR_MIN       20
`define IRB_HDR_MAX       28
`define IRB_ONE_MIN       9
`define IRB_ONE_MAX       15
`define IRB_ZERO_MIN      3
`define IRB_GAP_MAX       10
`define IRB_FRAME_BITS    12
`define IRB_NINE_KEY      7'h08
`define IRB_NINE_RUN      5

// ---------------------------------------------------------------------------
// Translation values
// ---------------------------------------------------------------------------
`define IRB_KEY_LAST      7'h08
`define IRB_KEY_ZERO      7'h09
`define IRB_KEY_ENTER     7'h0B
`define IRB_KEY_POWER     7'h15
`define IRB_KEY_JUMP      7'h3B
`define IRB_ASC_ONE       7'h31
`define IRB_ASC_EIGHT     7'h38
`define IRB_ASC_NINE      7'h39
`define IRB_ASC_ZERO      7'h30
`define IRB_ASC_CR        7'h0D
`define IRB_ASC_DOT       7'h2E
`define IRB_ASC_BS        7'h08

`endif

// file: irb_pkg.sv
/*
  Types shared by the bridge: state enumerations of the decoder and sender.
  Assumes nothing of its surroundings.
*/
package irb_pkg;

  // -------------------------------------------------------------------------
  // State types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_STOP} irb_tx_state_t;
  typedef enum logic [1:0] {DEC_HUNT, DEC_HEAD, DEC_GAP, DEC_BIT} irb_dec_state_t;

endpackage
